// file: verilog/synth_prog_defines.svh
// Constants for the synthesizer divider programming port
`ifndef SYNTH_PROG_DEFINES_SVH
`define SYNTH_PROG_DEFINES_SVH

// ----------------------------------------------------------------
// Serial frame layout, test bits first, feedback divider LSB last
// ----------------------------------------------------------------
`define SP_FRAME_LEN   13
`define SP_TEST_HI     12
`define SP_TEST_LO     11
`define SP_NDIV_HI     10
`define SP_NDIV_LO     9
`define SP_MDIV_HI     8
`define SP_MDIV_LO     0

// ----------------------------------------------------------------
// Reset values of the stored settings
// ----------------------------------------------------------------
`define SP_MDIV_RST    9'h018
`define SP_NDIV_RST    2'h0
`define SP_TEST_RST    2'h0

// ----------------------------------------------------------------
// Input prescaler ratios
// ----------------------------------------------------------------
`define SP_PRE_LOW     4'h8
`define SP_PRE_FLOAT   4'h1
`define SP_PRE_HIGH    4'h4

// ----------------------------------------------------------------
// Diagnostic output selections
// ----------------------------------------------------------------
`define SP_DIAG_LOW    2'h0
`define SP_DIAG_SDATA  2'h1
`define SP_DIAG_FBDIV  2'h2
`define SP_DIAG_FOUT   2'h3

`endif

// file: verilog/synth_prog_pkg.sv
// Types shared by the synthesizer divider programming port
package synth_prog_pkg;

    // Level seen on the three-level prescaler select pin
    typedef enum logic [1:0] {
        LEVEL_LOW,
        LEVEL_FLOAT,
        LEVEL_HIGH
    } tri_level_t;

    // Programming mode the port is in
    typedef enum logic {
        PROG_PARALLEL,
        PROG_SERIAL
    } prog_mode_t;

endpackage

// file: verilog/synth_divider_program_port.sv
// Divider programming, mode control and output dividers of the synthesizer
`timescale 1ns/1ps
`default_nettype none
`include "synth_prog_defines.svh"

// Operation
// - Parallel strobe low passes divider pins straight to the dividers.
// - Parallel strobe rising captures pins; held until strobe falls or serial load.
// - Diagnostic output stays low while in parallel mode.
// - Prescaler set only by three-level pin: low 8, float 1, high 4.
// - Feedback divider value is the plain binary of its nine bits.
// - Serial mode: parallel strobe high, load low; shift on clock rise.
// - Serial load rising moves shift register into the dividers.
// - Serial load falling latches divider values against further shifting.
// - Serial load high: each shift clock rise passes data to dividers.
// - Serial frame carries feedback, output divider and two test bits.
// - Test bits pick diagnostic: low, serial data, feedback, synth output.
// - Master reset clears dividers: true outputs low, complements high.
// - Master reset keeps stored feedback, output divider and test values.
// - Reference select high picks crystal, low picks the test clock.
// - Bypass select chooses PLL mode or reference bypass mode.
// - Output divider gives 50% duty at every ratio.
// - Output divider bits 00,01,10,11 give ratios 1,2,4,8.
module synth_divider_program_port #(
    parameter int MDIV_W = 9,
    parameter int NDIV_W = 2
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              parallel_load_strobe_n,
    input  wire logic [MDIV_W-1:0] feedback_divider_bits,
    input  wire logic [NDIV_W-1:0] output_divider_bits,
    input  wire logic              serial_load_strobe,
    input  wire logic              serial_shift_clock,
    input  wire logic              serial_data_in,
    input  wire logic              global_reset_in,
    input  wire logic [1:0]        input_divide_level,
    input  wire logic              reference_source_select,
    input  wire logic              pll_bypass_select,
    input  wire logic              xtal_tick,
    input  wire logic              test_clk_tick,
    input  wire logic              vco_tick,
    output logic [MDIV_W-1:0]      feedback_divide_value,
    output logic [NDIV_W-1:0]      output_divide_code,
    output logic [1:0]             diag_select,
    output logic [3:0]             prescale_ratio,
    output logic                   reference_is_crystal,
    output logic                   pll_mode_active,
    output logic                   pfd_ref_tick,
    output logic                   feedback_div_out,
    output logic                   diag_out,
    output logic                   serial_mode,
    output logic                   synth_out_a_true,
    output logic                   synth_out_a_comp,
    output logic                   synth_out_b_true,
    output logic                   synth_out_b_comp
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Output divider code to ratio, one-hot power of two
    function automatic logic [3:0] out_ratio(input logic [1:0] code);
        out_ratio = 4'h1 << code;
    endfunction

    // Three-level pin to prescaler ratio; serial path never reaches it
    function automatic logic [3:0] pre_ratio(input logic [1:0] lvl);
        case (lvl)
            synth_prog_pkg::LEVEL_LOW:  pre_ratio = `SP_PRE_LOW;
            synth_prog_pkg::LEVEL_HIGH: pre_ratio = `SP_PRE_HIGH;
            default:                    pre_ratio = `SP_PRE_FLOAT;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Programming state
    // ----------------------------------------------------------------
    logic [MDIV_W-1:0]         m_q, m_d;
    logic [NDIV_W-1:0]         n_q, n_d;
    logic [1:0]                t_q, t_d;
    logic [`SP_FRAME_LEN-1:0]  sh_q, sh_d;
    synth_prog_pkg::prog_mode_t mode_q, mode_d;
    logic                      sclk_q, sload_q, np_q;
    logic                      sclk_rise, sload_rise, np_rise;
    logic [`SP_FRAME_LEN-1:0]  shifted;

    // Edge detection on the synchronous programming inputs
    assign sclk_rise  = serial_shift_clock & ~sclk_q;
    assign sload_rise = serial_load_strobe & ~sload_q;
    assign np_rise    = parallel_load_strobe_n & ~np_q;
    assign shifted    = {sh_q[`SP_FRAME_LEN-2:0], serial_data_in};

    // Next values of stored settings, shift register and mode
    always_comb begin
        m_d    = m_q;
        n_d    = n_q;
        t_d    = t_q;
        sh_d   = sh_q;
        mode_d = mode_q;
        if (!parallel_load_strobe_n) begin
            m_d    = feedback_divider_bits;
            n_d    = output_divider_bits;
            mode_d = synth_prog_pkg::PROG_PARALLEL;
        end else if (np_rise) begin
            m_d    = feedback_divider_bits;
            n_d    = output_divider_bits;
            mode_d = synth_prog_pkg::PROG_PARALLEL;
        end else if (sload_rise) begin
            // Shift register contents go to the dividers
            m_d    = sh_q[`SP_MDIV_HI:`SP_MDIV_LO];
            n_d    = sh_q[`SP_NDIV_HI:`SP_NDIV_LO];
            t_d    = sh_q[`SP_TEST_HI:`SP_TEST_LO];
            mode_d = synth_prog_pkg::PROG_SERIAL;
        end else if (sclk_rise) begin
            sh_d   = shifted;
            mode_d = synth_prog_pkg::PROG_SERIAL;
            if (serial_load_strobe) begin
                // Strobe held high: shifted data flows straight through
                m_d = shifted[`SP_MDIV_HI:`SP_MDIV_LO];
                n_d = shifted[`SP_NDIV_HI:`SP_NDIV_LO];
                t_d = shifted[`SP_TEST_HI:`SP_TEST_LO];
            end
        end
        // With the strobe low the settings simply hold, so shifting
        // after a falling load edge leaves the dividers alone
    end

    // Registers of the programming state; master reset does not touch them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            m_q     <= `SP_MDIV_RST;
            n_q     <= `SP_NDIV_RST;
            t_q     <= `SP_TEST_RST;
            sh_q    <= '0;
            mode_q  <= synth_prog_pkg::PROG_PARALLEL;
            sclk_q  <= 1'b0;
            sload_q <= 1'b0;
            np_q    <= 1'b0;
        end else begin
            m_q     <= m_d;
            n_q     <= n_d;
            t_q     <= t_d;
            sh_q    <= sh_d;
            mode_q  <= mode_d;
            sclk_q  <= serial_shift_clock;
            sload_q <= serial_load_strobe;
            np_q    <= parallel_load_strobe_n;
        end
    end

    // ----------------------------------------------------------------
    // Reference, prescaler and divider chain
    // ----------------------------------------------------------------
    logic              ref_tick, src_tick;
    logic [3:0]        pre_ratio_now, n_ratio;
    logic [3:0]        pcnt_q, pcnt_d;
    logic              pfd_q, pfd_d;
    logic              vph_q, vph_d;
    logic [MDIV_W-1:0] fcnt_q, fcnt_d;
    logic              fb_q, fb_d;
    logic [3:0]        ocnt_q, ocnt_d;
    logic              out_q, out_d;

    assign ref_tick      = reference_source_select ? xtal_tick
                                                   : test_clk_tick;
    assign src_tick      = pll_bypass_select ? vco_tick : ref_tick;
    assign pre_ratio_now = pre_ratio(input_divide_level);
    assign n_ratio       = out_ratio(n_q);

    // Next values of the counters; master reset clears all of them
    always_comb begin
        pcnt_d = pcnt_q;
        pfd_d  = 1'b0;
        vph_d  = vph_q;
        fcnt_d = fcnt_q;
        fb_d   = fb_q;
        ocnt_d = ocnt_q;
        out_d  = out_q;
        if (global_reset_in) begin
            pcnt_d = '0;
            vph_d  = 1'b0;
            fcnt_d = '0;
            fb_d   = 1'b0;
            ocnt_d = '0;
            out_d  = 1'b0;
        end else begin
            // Prescaler: one phase detector tick per ratio reference ticks
            if (ref_tick) begin
                if (pcnt_q >= pre_ratio_now - 4'h1) begin
                    pcnt_d = '0;
                    pfd_d  = 1'b1;
                end else begin
                    pcnt_d = pcnt_q + 4'h1;
                end
            end
            if (src_tick) begin
                // Each source tick is one half period of the source clock
                vph_d = ~vph_q;
                if (!vph_q) begin
                    // Feedback divider counts whole source periods
                    if (fcnt_q + 9'h001 >= m_q) begin
                        fcnt_d = '0;
                    end else begin
                        fcnt_d = fcnt_q + 9'h001;
                    end
                    fb_d = (fcnt_d < {1'b0, m_q[MDIV_W-1:1]});
                end
                // Output toggles every ratio half periods: 50% duty
                if (ocnt_q >= n_ratio - 4'h1) begin
                    ocnt_d = '0;
                    out_d  = ~out_q;
                end else begin
                    ocnt_d = ocnt_q + 4'h1;
                end
            end
        end
    end

    // Counter registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pcnt_q <= '0;
            pfd_q  <= 1'b0;
            vph_q  <= 1'b0;
            fcnt_q <= '0;
            fb_q   <= 1'b0;
            ocnt_q <= '0;
            out_q  <= 1'b0;
        end else begin
            pcnt_q <= pcnt_d;
            pfd_q  <= pfd_d;
            vph_q  <= vph_d;
            fcnt_q <= fcnt_d;
            fb_q   <= fb_d;
            ocnt_q <= ocnt_d;
            out_q  <= out_d;
        end
    end

    // ----------------------------------------------------------------
    // Diagnostic output selection
    // ----------------------------------------------------------------
    logic diag_d;

    // Parallel mode forces low whatever the test bits say
    always_comb begin
        if (mode_q == synth_prog_pkg::PROG_PARALLEL) begin
            diag_d = 1'b0;
        end else begin
            case (t_q)
                `SP_DIAG_LOW:   diag_d = 1'b0;
                `SP_DIAG_SDATA: diag_d = serial_data_in;
                `SP_DIAG_FBDIV: diag_d = fb_q;
                `SP_DIAG_FOUT:  diag_d = out_q;
                default:        diag_d = 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------

    // All module outputs come from these flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            feedback_divide_value <= `SP_MDIV_RST;
            output_divide_code    <= `SP_NDIV_RST;
            diag_select           <= `SP_TEST_RST;
            prescale_ratio        <= `SP_PRE_FLOAT;
            reference_is_crystal  <= 1'b0;
            pll_mode_active       <= 1'b0;
            pfd_ref_tick          <= 1'b0;
            feedback_div_out      <= 1'b0;
            diag_out              <= 1'b0;
            serial_mode           <= 1'b0;
            synth_out_a_true      <= 1'b0;
            synth_out_a_comp      <= 1'b1;
            synth_out_b_true      <= 1'b0;
            synth_out_b_comp      <= 1'b1;
        end else begin
            feedback_divide_value <= m_q;
            output_divide_code    <= n_q;
            diag_select           <= t_q;
            prescale_ratio        <= pre_ratio_now;
            reference_is_crystal  <= reference_source_select;
            pll_mode_active       <= pll_bypass_select;
            pfd_ref_tick          <= pfd_q;
            feedback_div_out      <= fb_q;
            diag_out              <= diag_d;
            serial_mode           <= (mode_q == synth_prog_pkg::PROG_SERIAL);
            // Both output pairs follow the output divider
            synth_out_a_true      <= out_q;
            synth_out_a_comp      <= ~out_q;
            synth_out_b_true      <= out_q;
            synth_out_b_comp      <= ~out_q;
        end
    end

endmodule
`default_nettype wire

// file: test/synth_prog_properties.sv
// Concurrent checks on the divider programming port
`timescale 1ns/1ps
`default_nettype none
module synth_prog_properties (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       parallel_load_strobe_n,
    input wire logic [8:0] feedback_divider_bits,
    input wire logic [1:0] output_divider_bits,
    input wire logic       serial_load_strobe,
    input wire logic       serial_data_in,
    input wire logic       global_reset_in,
    input wire logic [1:0] input_divide_level,
    input wire logic       reference_source_select,
    input wire logic       pll_bypass_select,
    input wire logic [8:0] feedback_divide_value,
    input wire logic [1:0] output_divide_code,
    input wire logic [1:0] diag_select,
    input wire logic [3:0] prescale_ratio,
    input wire logic       reference_is_crystal,
    input wire logic       pll_mode_active,
    input wire logic       diag_out,
    input wire logic       serial_mode,
    input wire logic       synth_out_a_true,
    input wire logic       synth_out_a_comp
);
    // ------------------------------------------------------------
    // Programming and output checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Strobe low long enough for pins to reach the outputs
    sequence s_par_open;
        (!parallel_load_strobe_n)[*4];
    endsequence
    // Strobe rise followed by a quiet serial side
    sequence s_par_capture;
        $rose(parallel_load_strobe_n) ##0
            (parallel_load_strobe_n && !serial_load_strobe)[*4];
    endsequence
    a_par_pass: assert property (s_par_open |->
        {feedback_divide_value, output_divide_code} ==
        $past({feedback_divider_bits, output_divider_bits}, 2))
        else $error("pins not passed to dividers");
    a_par_capture: assert property (s_par_capture |->
        feedback_divide_value == $past(feedback_divider_bits, 3))
        else $error("captured value not held");
    a_diag_parallel: assert property (s_par_open |-> !diag_out)
        else $error("diagnostic high in parallel mode");
    a_serial_hold: assert property (
        (parallel_load_strobe_n && !serial_load_strobe)[*5] |->
        $stable({feedback_divide_value, output_divide_code, diag_select}))
        else $error("settings moved without a load");
    a_diag_mirror: assert property (
        (serial_mode && diag_select == 2'h1)[*4] |->
        diag_out == $past(serial_data_in, 1))
        else $error("diagnostic not following serial data");
    a_prescale_map: assert property (
        $stable(input_divide_level)[*4] |-> prescale_ratio ==
        (input_divide_level == 2'h0 ? 4'h8 :
        (input_divide_level == 2'h2 ? 4'h4 : 4'h1)))
        else $error("prescaler ratio wrong");
    a_source_select: assert property (
        $stable({reference_source_select, pll_bypass_select})[*3] |->
        {reference_is_crystal, pll_mode_active} ==
        {reference_source_select, pll_bypass_select})
        else $error("source selection wrong");
    a_reset_quiet: assert property (global_reset_in[*4] |->
        !synth_out_a_true && synth_out_a_comp)
        else $error("outputs not cleared by master reset");
    a_comp_inverse: assert property (
        synth_out_a_comp != synth_out_a_true)
        else $error("complement output not inverse");
endmodule
bind synth_divider_program_port synth_prog_properties chk (
    .mclk, .rst_n, .parallel_load_strobe_n, .feedback_divider_bits,
    .output_divider_bits, .serial_load_strobe, .serial_data_in,
    .global_reset_in, .input_divide_level, .reference_source_select,
    .pll_bypass_select, .feedback_divide_value, .output_divide_code,
    .diag_select, .prescale_ratio, .reference_is_crystal,
    .pll_mode_active, .diag_out, .serial_mode, .synth_out_a_true,
    .synth_out_a_comp);
`default_nettype wire

// file: test/prog_host.sv
// Host controller model driving the programming pins
`timescale 1ns/1ps
`default_nettype none
module prog_host (
    input  wire logic  mclk,
    output logic       parallel_load_strobe_n,
    output logic [8:0] feedback_divider_bits,
    output logic [1:0] output_divider_bits,
    output logic       serial_load_strobe,
    output logic       serial_shift_clock,
    output logic       serial_data_in
);
    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Pins rest low, except the feedback divider bits, which start at 018
    initial begin
        parallel_load_strobe_n = 1'b0;
        feedback_divider_bits = 9'h018;
        output_divider_bits = 2'h0;
        serial_load_strobe = 1'b0;
        serial_shift_clock = 1'b0;
        serial_data_in = 1'b0;
    end
    task automatic step;
        @(posedge mclk);
        #1;
    endtask
    // Parallel setting; pins wander once captured
    task automatic par_load(input logic [8:0] m, input logic [1:0] n,
                            input logic latch);
        step();
        parallel_load_strobe_n = 1'b0;
        feedback_divider_bits = m;
        output_divider_bits = n;
        if (latch) begin
            step();
            parallel_load_strobe_n = 1'b1;
            step();
            feedback_divider_bits = ~m;
            output_divider_bits = ~n;
        end
    endtask
    // Serial frame, top test bit first; shift clock idles low
    task automatic ser_frame(input logic [12:0] f, input logic thru,
                             input logic load);
        step();
        parallel_load_strobe_n = 1'b1;
        step();
        serial_load_strobe = thru;
        for (int i = 12; i >= 0; i--) begin
            step();
            serial_data_in = f[i];
            serial_shift_clock = 1'b1;
            step();
            serial_shift_clock = 1'b0;
        end
        step();
        serial_data_in = 1'b0;
        if (load) begin
            step();
            serial_load_strobe = 1'b1;
        end
        step();
        serial_load_strobe = 1'b0;
    endtask
    task automatic drive_sdi(input logic v);
        step();
        serial_data_in = v;
    endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the divider programming port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    miscompares++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       global_reset_in = 1'b0;
    logic       reference_source_select = 1'b1;
    logic       pll_bypass_select = 1'b1;
    logic       xtal_tick = 1'b0;
    logic       test_clk_tick = 1'b0;
    logic       vco_tick = 1'b0;
    logic [1:0] input_divide_level = 2'h1;
    logic [3:0] pexp [4] = '{4'h8, 4'h1, 4'h4, 4'h1};
    wire logic  parallel_load_strobe_n, serial_load_strobe;
    wire logic  serial_shift_clock, serial_data_in;
    wire logic [8:0] feedback_divider_bits, feedback_divide_value;
    wire logic [1:0] output_divider_bits, output_divide_code, diag_select;
    wire logic [3:0] prescale_ratio;
    wire logic  reference_is_crystal, pll_mode_active, pfd_ref_tick;
    wire logic  feedback_div_out, diag_out, serial_mode;
    wire logic  synth_out_a_true, synth_out_a_comp;
    wire logic  synth_out_b_true, synth_out_b_comp;
    int         miscompares = 0;
    int         check_count = 0;
    int         cyc = 0;
    prog_host host (.mclk, .parallel_load_strobe_n, .feedback_divider_bits,
        .output_divider_bits, .serial_load_strobe, .serial_shift_clock,
        .serial_data_in);
    synth_divider_program_port uut (.mclk, .rst_n, .parallel_load_strobe_n,
        .feedback_divider_bits, .output_divider_bits, .serial_load_strobe,
        .serial_shift_clock, .serial_data_in, .global_reset_in,
        .input_divide_level, .reference_source_select, .pll_bypass_select,
        .xtal_tick, .test_clk_tick, .vco_tick, .feedback_divide_value,
        .output_divide_code, .diag_select, .prescale_ratio,
        .reference_is_crystal, .pll_mode_active, .pfd_ref_tick,
        .feedback_div_out, .diag_out, .serial_mode, .synth_out_a_true,
        .synth_out_a_comp, .synth_out_b_true, .synth_out_b_comp);
    // ------------------------------------------------------------
    // Clock, reference ticks and run limit
    // ------------------------------------------------------------
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        #1;
        cyc++;
        xtal_tick = cyc[0];
        test_clk_tick = (cyc[1:0] == 2'h3);
        if (cyc == 6000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Transparent pins for every output code, then capture on rise
    task automatic t_parallel;
        for (int c = 0; c < 4; c++) begin
            host.par_load(9'h017 + 9'(c), 2'(c), 1'b0);
            wt(3);
            `CHK("fb_value", 9'h017 + 9'(c), feedback_divide_value)
            `CHK("out_code", 2'(c), output_divide_code)
            `CHK("diag_par", 1'b0, diag_out)
        end
        host.par_load(9'h01b, 2'h3, 1'b1);
        wt(4);
        `CHK("fb_held", 9'h01b, feedback_divide_value)
        `CHK("out_held", 2'h3, output_divide_code)
    endtask
    // Load, pass-through, shift without load, load again
    task automatic t_serial;
        host.ser_frame({2'h0, 2'h2, 9'h019}, 1'b0, 1'b1);
        wt(3);
        `CHK("ser_m", 9'h019, feedback_divide_value)
        `CHK("ser_n", 2'h2, output_divide_code)
        `CHK("ser_mode", 1'b1, serial_mode)
        host.ser_frame({2'h1, 2'h1, 9'h01a}, 1'b1, 1'b0);
        wt(3);
        `CHK("thru_m", 9'h01a, feedback_divide_value)
        `CHK("thru_t", 2'h1, diag_select)
        host.ser_frame({2'h3, 2'h3, 9'h017}, 1'b0, 1'b0);
        wt(3);
        `CHK("kept_m", 9'h01a, feedback_divide_value)
        host.ser_frame({2'h3, 2'h3, 9'h017}, 1'b0, 1'b1);
        wt(3);
        `CHK("load_t", 2'h3, diag_select)
    endtask
    // Diagnostic selections: mirror, divider, low
    task automatic t_diag;
        host.ser_frame({2'h1, 2'h0, 9'h018}, 1'b0, 1'b1);
        for (int v = 0; v < 2; v++) begin
            host.drive_sdi(v[0]);
            wt(3);
            `CHK("diag_mirror", v[0], diag_out)
        end
        host.ser_frame({2'h2, 2'h0, 9'h018}, 1'b0, 1'b1);
        host.ser_frame({2'h0, 2'h3, 9'h018}, 1'b0, 1'b1);
        wt(3);
        `CHK("diag_low", 1'b0, diag_out)
    endtask
    // Ratios and duty of the output divider, then master reset
    task automatic t_outdiv;
        int   hi;
        int   tg;
        int   rs;
        logic pv;
        logic pd;
        vco_tick = 1'b1;
        for (int c = 0; c < 4; c++) begin
            host.ser_frame({2'h3, 2'(c), 9'h018}, 1'b0, 1'b1);
            wt(20);
            hi = 0;
            tg = 0;
            rs = 0;
            pv = synth_out_a_true;
            pd = diag_out;
            for (int i = 0; i < (16 << c); i++) begin
                wt(1);
                hi += synth_out_a_true;
                tg += (synth_out_a_true !== pv);
                rs += (diag_out !== pd);
                pv = synth_out_a_true;
                pd = diag_out;
            end
            `CHK("toggles", 16, tg)
            `CHK("high_cycles", 8 << c, hi)
            `CHK("diag_fout", 16, rs)
        end
        // Feedback of 24 source periods is 48 cycles: two rises in 96
        host.ser_frame({2'h2, 2'h3, 9'h018}, 1'b0, 1'b1);
        wt(4);
        tg = 0;
        rs = 0;
        pv = feedback_div_out;
        pd = diag_out;
        for (int i = 0; i < 96; i++) begin
            wt(1);
            tg += (feedback_div_out && !pv);
            rs += (diag_out && !pd);
            pv = feedback_div_out;
            pd = diag_out;
        end
        `CHK("fb_rises", 2, tg)
        `CHK("diag_fb", 2, rs)
        global_reset_in = 1'b1;
        wt(4);
        `CHK("b_true", 1'b0, synth_out_b_true)
        `CHK("b_comp", 1'b1, synth_out_b_comp)
        `CHK("rst_m", 9'h018, feedback_divide_value)
        `CHK("rst_n_code", 2'h3, output_divide_code)
        global_reset_in = 1'b0;
        vco_tick = 1'b0;
    endtask
    // Prescaler levels and source selection
    task automatic t_select;
        int pf;
        for (int l = 0; l < 4; l++) begin
            input_divide_level = 2'(l);
            wt(5);
            `CHK("prescale", pexp[l], prescale_ratio)
            // Crystal ticks every other cycle: 24 ticks in 48 cycles
            pf = 0;
            repeat (48) begin
                wt(1);
                pf += pfd_ref_tick;
            end
            `CHK("pfd_ticks", 24 / pexp[l], pf)
        end
        for (int s = 0; s < 2; s++) begin
            reference_source_select = s[0];
            pll_bypass_select = ~s[0];
            wt(3);
            `CHK("ref_xtal", s[0], reference_is_crystal)
            `CHK("pll_mode", ~s[0], pll_mode_active)
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence
    initial begin
        wt(10);
        rst_n = 1'b1;
        t_parallel();
        t_serial();
        t_diag();
        t_outdiv();
        t_select();
        summarize();
    end
endmodule
`default_nettype wire
